// ---- dmic_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmic_top (
  // Clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_nrst,
  // Space enable register
  input  wire logic                        i_cache_en_wr,
  input  wire logic                        i_dram_space_cache_en,
  input  wire logic                        i_chipsel_space3_cache_en,
  input  wire logic                        i_chipsel_space2_cache_en,
  input  wire logic                        i_chipsel_space1_cache_en,
  input  wire logic                        i_chipsel_space0_cache_en,
  output logic      [dmic_pkg::EN_W-1:0]   o_cache_space_enable_reg,
  // Fetch path
  input  wire logic                        i_fetch_req,
  input  wire logic                        i_fetch_cacheable,
  input  wire logic [31:0]                 i_fetch_addr,
  output logic                             o_fetch_ack,
  output logic      [dmic_pkg::LINE_W-1:0] o_fetch_rdata,
  // Direct array access
  input  wire logic                        i_arr_req,
  input  wire logic                        i_arr_wr,
  input  wire logic [31:0]                 i_arr_addr,
  input  wire logic [dmic_pkg::LINE_W-1:0] i_arr_wdata,
  output logic                             o_arr_ack,
  output logic      [dmic_pkg::LINE_W-1:0] o_arr_rdata,
  // External bus controller
  input  wire logic                        i_ext_done,
  input  wire logic [dmic_pkg::LINE_W-1:0] i_ext_rdata,
  input  wire logic                        i_ras_down_mode,
  output logic                             o_ext_req,
  output logic      [31:0]                 o_ext_addr,
  output logic                             o_ext_dram,
  output logic                             o_cs_extend,
  output logic                             o_ras_extend,
  output logic                             o_bus_delay
);
  dmic_pkg::dmic_state_e       state, next_state;
  logic [dmic_pkg::LINE_W-1:0] fill_data, rd_data, w_data;
  logic [dmic_pkg::IDX_W-1:0]  rd_idx, f_idx, w_idx;
  logic [dmic_pkg::TAG_W-1:0]  rd_tag, f_tag, w_tag;
  logic [1:0]                  cs_sel;
  logic                        post_miss, cur_fill, cur_dram, rd_valid, is_cs, is_dram;
  logic                        space_en, cacheable, hit, take_fetch, take_arr, cache_on;
  logic                        in_tag_win, in_data_win, we_tag, we_data, w_valid;

  // ------------------------------------------------------------
  // Space enable register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cache_space_enable_reg <= dmic_pkg::EN_RESET;
    end else if (i_cache_en_wr) begin
      o_cache_space_enable_reg <= {i_dram_space_cache_en, i_chipsel_space3_cache_en,
                                   i_chipsel_space2_cache_en, i_chipsel_space1_cache_en,
                                   i_chipsel_space0_cache_en};
    end
  end
  assign cache_on = |o_cache_space_enable_reg;

  // ------------------------------------------------------------
  // Lookup
  // ------------------------------------------------------------
  assign f_idx   = i_fetch_addr[dmic_pkg::IDX_MSB:dmic_pkg::IDX_LSB];
  assign f_tag   = i_fetch_addr[dmic_pkg::TAG_MSB:dmic_pkg::TAG_LSB];
  assign cs_sel  = i_fetch_addr[dmic_pkg::CSSEL_MSB:dmic_pkg::CSSEL_LSB];
  assign is_cs   = i_fetch_addr[dmic_pkg::SPACE_MSB:dmic_pkg::SPACE_LSB] == dmic_pkg::SPACE_CS;
  assign is_dram = i_fetch_addr[dmic_pkg::SPACE_MSB:dmic_pkg::SPACE_LSB] == dmic_pkg::SPACE_DRAM;
  always_comb begin
    space_en = 1'b0;
    if (is_dram) begin
      space_en = o_cache_space_enable_reg[dmic_pkg::EN_DRAM_BIT];
    end else if (is_cs) begin
      space_en = o_cache_space_enable_reg[cs_sel];
    end
  end
  assign cacheable  = i_fetch_cacheable && space_en;
  assign hit        = cacheable && rd_valid && (rd_tag == f_tag);
  assign take_fetch = (state == dmic_pkg::S_IDLE) && i_fetch_req && !o_fetch_ack;
  assign take_arr   = (state == dmic_pkg::S_IDLE) && !i_fetch_req && i_arr_req && !o_arr_ack;
  assign rd_idx     = i_fetch_req ? f_idx : i_arr_addr[dmic_pkg::IDX_MSB:dmic_pkg::IDX_LSB];
  assign in_tag_win  = (i_arr_addr >= dmic_pkg::TAG_WIN_BASE) && (i_arr_addr <= dmic_pkg::TAG_WIN_LAST);
  assign in_data_win = (i_arr_addr >= dmic_pkg::DATA_WIN_BASE) && (i_arr_addr <= dmic_pkg::DATA_WIN_LAST);

  // ------------------------------------------------------------
  // Array write selection
  // ------------------------------------------------------------
  always_comb begin
    we_tag  = 1'b0;
    we_data = 1'b0;
    w_idx   = o_ext_addr[dmic_pkg::IDX_MSB:dmic_pkg::IDX_LSB];
    w_tag   = o_ext_addr[dmic_pkg::TAG_MSB:dmic_pkg::TAG_LSB];
    w_valid = 1'b1;
    w_data  = fill_data;
    if (state == dmic_pkg::S_EXTEND) begin
      we_tag  = 1'b1;
      we_data = 1'b1;
    end else if (take_arr && i_arr_wr && !cache_on) begin
      w_idx   = i_arr_addr[dmic_pkg::IDX_MSB:dmic_pkg::IDX_LSB];
      w_tag   = i_arr_wdata[dmic_pkg::TAG_MSB:dmic_pkg::TAG_LSB];
      w_valid = i_arr_wdata[dmic_pkg::VALID_BIT];
      w_data  = i_arr_wdata;
      we_tag  = in_tag_win;
      we_data = in_data_win;
    end
  end

  dmic_array u_array (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_we_tag  (we_tag),
    .i_we_data (we_data),
    .i_widx    (w_idx),
    .i_wtag    (w_tag),
    .i_wvalid  (w_valid),
    .i_wdata   (w_data),
    .i_ridx    (rd_idx),
    .o_rtag    (rd_tag),
    .o_rvalid  (rd_valid),
    .o_rdata   (rd_data)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      dmic_pkg::S_IDLE: begin
        if (take_fetch) begin
          if (cacheable && !hit && !post_miss) begin
            next_state = dmic_pkg::S_PENALTY;
          end else if (!(hit && !post_miss)) begin
            next_state = dmic_pkg::S_FILL;
          end
        end
      end
      dmic_pkg::S_PENALTY: next_state = dmic_pkg::S_FILL;
      dmic_pkg::S_FILL: begin
        if (i_ext_done) begin
          next_state = cur_fill ? dmic_pkg::S_EXTEND : dmic_pkg::S_IDLE;
        end
      end
      dmic_pkg::S_EXTEND: begin
        next_state = (cur_dram && i_ras_down_mode) ? dmic_pkg::S_DELAY : dmic_pkg::S_IDLE;
      end
      dmic_pkg::S_DELAY: next_state = dmic_pkg::S_IDLE;
      default: next_state = dmic_pkg::S_IDLE;
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= dmic_pkg::S_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // Miss history drives penalty skip and forced refill
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      post_miss <= 1'b0;
    end else if (take_fetch && cacheable) begin
      post_miss <= !hit;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cur_fill   <= 1'b0;
      cur_dram   <= 1'b0;
      o_ext_addr <= '0;
      o_ext_dram <= 1'b0;
    end else if (take_fetch) begin
      cur_fill   <= cacheable;
      cur_dram   <= is_dram;
      o_ext_addr <= i_fetch_addr;
      o_ext_dram <= is_dram;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      fill_data <= '0;
    end else if ((state == dmic_pkg::S_FILL) && i_ext_done) begin
      fill_data <= i_ext_rdata;
    end
  end

  // ------------------------------------------------------------
  // Bus controls
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_req    <= 1'b0;
      o_cs_extend  <= 1'b0;
      o_ras_extend <= 1'b0;
      o_bus_delay  <= 1'b0;
    end else begin
      o_ext_req    <= next_state == dmic_pkg::S_FILL;
      o_cs_extend  <= (next_state == dmic_pkg::S_EXTEND) && !cur_dram;
      o_ras_extend <= (next_state == dmic_pkg::S_EXTEND) && cur_dram;
      o_bus_delay  <= next_state == dmic_pkg::S_DELAY;
    end
  end

  // ------------------------------------------------------------
  // Fetch answer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fetch_ack   <= 1'b0;
      o_fetch_rdata <= '0;
    end else begin
      o_fetch_ack <= 1'b0;
      if (take_fetch && hit && !post_miss) begin
        o_fetch_ack   <= 1'b1;
        o_fetch_rdata <= rd_data;
      end else if (state == dmic_pkg::S_EXTEND) begin
        o_fetch_ack   <= 1'b1;
        o_fetch_rdata <= fill_data;
      end else if ((state == dmic_pkg::S_FILL) && i_ext_done && !cur_fill) begin
        o_fetch_ack   <= 1'b1;
        o_fetch_rdata <= i_ext_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Direct array answer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arr_ack   <= 1'b0;
      o_arr_rdata <= '0;
    end else begin
      o_arr_ack <= take_arr;
      if (take_arr) begin
        if (cache_on || i_arr_wr) begin
          o_arr_rdata <= dmic_pkg::LOCKED_RDATA;
        end else if (in_tag_win) begin
          o_arr_rdata <= (32'(rd_tag) << dmic_pkg::TAG_LSB) | 32'(rd_valid);
        end else if (in_data_win) begin
          o_arr_rdata <= rd_data;
        end else begin
          o_arr_rdata <= dmic_pkg::LOCKED_RDATA;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_fill_start;
    (state == dmic_pkg::S_FILL) && o_ext_req;
  endsequence
  sequence s_ras_delay;
    o_bus_delay ##1 !o_bus_delay;
  endsequence
  property p_miss_penalty;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (take_fetch && cacheable && !hit && !post_miss) |=> !o_ext_req ##1 s_fill_start;
  endproperty
  a_miss_penalty: assert property (p_miss_penalty) else $error("miss penalty not one cycle");
  property p_consec_miss;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (take_fetch && cacheable && !hit && post_miss) |=> s_fill_start;
  endproperty
  a_consec_miss: assert property (p_consec_miss) else $error("consecutive miss got a penalty");
  property p_post_miss_hit;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (take_fetch && hit && post_miss) |=> s_fill_start ##0 !post_miss;
  endproperty
  a_post_miss_hit: assert property (p_post_miss_hit) else $error("post-miss hit not refilled");
  property p_true_hit;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (take_fetch && hit && !post_miss) |=> o_fetch_ack && !o_ext_req && (o_fetch_rdata == $past(rd_data));
  endproperty
  a_true_hit: assert property (p_true_hit) else $error("hit not served from array");
  property p_cs_extend;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      ((state == dmic_pkg::S_FILL) && i_ext_done && cur_fill && !cur_dram)
        |=> o_cs_extend && !o_ras_extend && !o_ext_req ##1 !o_cs_extend;
  endproperty
  a_cs_extend: assert property (p_cs_extend) else $error("chip-select not extended one cycle");
  property p_ras_extend;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      ((state == dmic_pkg::S_FILL) && i_ext_done && cur_fill && cur_dram)
        |=> o_ras_extend && !o_cs_extend ##1 !o_ras_extend;
  endproperty
  a_ras_extend: assert property (p_ras_extend) else $error("RAS not extended one cycle");
  property p_ras_down;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      ((state == dmic_pkg::S_EXTEND) && cur_dram && i_ras_down_mode) |=> s_ras_delay;
  endproperty
  a_ras_down: assert property (p_ras_down) else $error("RAS-down delay missing");
  property p_locked;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (take_arr && cache_on) |-> !we_tag && !we_data ##1 o_arr_ack && (o_arr_rdata == dmic_pkg::LOCKED_RDATA);
  endproperty
  a_locked: assert property (p_locked) else $error("array window reachable while enabled");
  property p_fill_write;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (state == dmic_pkg::S_EXTEND) |-> we_tag && we_data && w_valid && (w_data == fill_data) ##1 o_fetch_ack;
  endproperty
  a_fill_write: assert property (p_fill_write) else $error("fill did not update entry");
  property p_enable_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      !i_cache_en_wr |=> $stable(o_cache_space_enable_reg);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable register changed unwritten");
endmodule : dmic_top
`default_nettype wire

// ---- dmic_pkg.sv ----
`default_nettype none
package dmic_pkg;
  // ------------------------------------------------------------
  // Array windows
  // ------------------------------------------------------------
  localparam logic [31:0] TAG_WIN_BASE  = 32'hFFFFF000;
  localparam logic [31:0] TAG_WIN_LAST  = 32'hFFFFF3FF;
  localparam logic [31:0] DATA_WIN_BASE = 32'hFFFFF400;
  localparam logic [31:0] DATA_WIN_LAST = 32'hFFFFF7FF;

  // ------------------------------------------------------------
  // Geometry and address fields
  // ------------------------------------------------------------
  localparam int ENTRIES = 256;
  localparam int IDX_W   = 8;
  localparam int TAG_W   = 15;
  localparam int LINE_W  = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int TAG_LSB = 10;
  localparam int TAG_MSB = 24;
  localparam int VALID_BIT = 0;

  // ------------------------------------------------------------
  // Space decode
  // ------------------------------------------------------------
  localparam int SPACE_MSB  = 31;
  localparam int SPACE_LSB  = 24;
  localparam int CSSEL_MSB  = 23;
  localparam int CSSEL_LSB  = 22;
  localparam logic [7:0] SPACE_CS   = 8'h00;
  localparam logic [7:0] SPACE_DRAM = 8'h01;

  // ------------------------------------------------------------
  // Space enable register
  // ------------------------------------------------------------
  localparam int EN_W        = 5;
  localparam int EN_DRAM_BIT = 4;
  localparam logic [EN_W-1:0] EN_RESET = 5'h00;
  localparam logic [LINE_W-1:0] LOCKED_RDATA = 32'h00000000;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_PENALTY = 3'b001,
    S_FILL    = 3'b010,
    S_EXTEND  = 3'b011,
    S_DELAY   = 3'b100
  } dmic_state_e;
endpackage : dmic_pkg
`default_nettype wire

// ---- dmic_array.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmic_array (
  // Clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_nrst,
  // Write port
  input  wire logic                        i_we_tag,
  input  wire logic                        i_we_data,
  input  wire logic [dmic_pkg::IDX_W-1:0]  i_widx,
  input  wire logic [dmic_pkg::TAG_W-1:0]  i_wtag,
  input  wire logic                        i_wvalid,
  input  wire logic [dmic_pkg::LINE_W-1:0] i_wdata,
  // Read port
  input  wire logic [dmic_pkg::IDX_W-1:0]  i_ridx,
  output logic      [dmic_pkg::TAG_W-1:0]  o_rtag,
  output logic                             o_rvalid,
  output logic      [dmic_pkg::LINE_W-1:0] o_rdata
);
  logic [dmic_pkg::TAG_W-1:0]  tag_mem  [dmic_pkg::ENTRIES];
  logic [dmic_pkg::LINE_W-1:0] data_mem [dmic_pkg::ENTRIES];
  logic [dmic_pkg::ENTRIES-1:0] valid;

  // ------------------------------------------------------------
  // Entry storage
  // ------------------------------------------------------------
  for (genvar e = 0; e < dmic_pkg::ENTRIES; e++) begin : g_entry
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
        valid[e]    <= 1'b0;
        tag_mem[e]  <= '0;
        data_mem[e] <= '0;
      end else begin
        if (i_we_tag && (i_widx == e[dmic_pkg::IDX_W-1:0])) begin
          tag_mem[e] <= i_wtag;
          valid[e]   <= i_wvalid;
        end
        if (i_we_data && (i_widx == e[dmic_pkg::IDX_W-1:0])) begin
          data_mem[e] <= i_wdata;
        end
      end
    end
  end

  assign o_rtag   = tag_mem[i_ridx];
  assign o_rvalid = valid[i_ridx];
  assign o_rdata  = data_mem[i_ridx];
endmodule : dmic_array
`default_nettype wire

// ---- dmic_ext_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmic_ext_model (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // Request side
  input  wire logic        i_ext_req,
  input  wire logic [31:0] i_ext_addr,
  input  wire logic        i_slow,
  // Answer side
  output logic             o_ext_done,
  output logic      [31:0] o_ext_rdata
);
  // ------------------------------------------------------------
  // Bus cycle timing
  // ------------------------------------------------------------
  logic [2:0] cnt;
  logic       fired;
  logic       fire;

  assign fire = i_ext_req && !fired && (cnt == (i_slow ? 3'h3 : 3'h0));

  // One answer per request; a new one only after the request drops
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt        <= 3'h0;
      fired      <= 1'b0;
      o_ext_done <= 1'b0;
    end else begin
      o_ext_done <= fire;
      if (!i_ext_req) begin
        cnt   <= 3'h0;
        fired <= 1'b0;
      end else if (fire) begin
        fired <= 1'b1;
      end else if (!fired) begin
        cnt <= cnt + 3'h1;
      end
    end
  end

  // Data is valid only with done; otherwise it toggles so stale use shows
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_rdata <= 32'h00000000;
    end else if (fire) begin
      o_ext_rdata <= i_ext_addr ^ 32'h5A5A0000;
    end else begin
      o_ext_rdata <= ~o_ext_rdata;
    end
  end
endmodule : dmic_ext_model
`default_nettype wire

// ---- dmic_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmic_tb_top;
  logic        clk, nrst, en_wr, f_req, f_cach, a_req, a_wr, ras_down, slow;
  logic [4:0]  en_val;
  logic [31:0] f_addr, a_addr, a_wdata, q, n;
  logic [7:0]  s;
  logic [4:0]  en_reg;
  logic        f_ack, a_ack, x_req, x_dram, cs_ext, ras_ext, b_dly, x_done;
  logic [31:0] f_rdata, a_rdata, x_addr, x_rdata;
  int          fail_count, checks;

  dmic_top dut (.i_clk_sys(clk), .i_nrst(nrst), .i_cache_en_wr(en_wr),
    .i_dram_space_cache_en(en_val[4]), .i_chipsel_space3_cache_en(en_val[3]),
    .i_chipsel_space2_cache_en(en_val[2]), .i_chipsel_space1_cache_en(en_val[1]),
    .i_chipsel_space0_cache_en(en_val[0]), .o_cache_space_enable_reg(en_reg),
    .i_fetch_req(f_req), .i_fetch_cacheable(f_cach), .i_fetch_addr(f_addr),
    .o_fetch_ack(f_ack), .o_fetch_rdata(f_rdata), .i_arr_req(a_req), .i_arr_wr(a_wr),
    .i_arr_addr(a_addr), .i_arr_wdata(a_wdata), .o_arr_ack(a_ack), .o_arr_rdata(a_rdata),
    .i_ext_done(x_done), .i_ext_rdata(x_rdata), .i_ras_down_mode(ras_down),
    .o_ext_req(x_req), .o_ext_addr(x_addr), .o_ext_dram(x_dram), .o_cs_extend(cs_ext),
    .o_ras_extend(ras_ext), .o_bus_delay(b_dly));

  dmic_ext_model bus (.i_clk_sys(clk), .i_nrst(nrst), .i_ext_req(x_req), .i_ext_addr(x_addr),
    .i_slow(slow), .o_ext_done(x_done), .o_ext_rdata(x_rdata));

  always #2.5 clk = ~clk;

  // ------------------------------------------------------------
  // Compare and access tasks
  // ------------------------------------------------------------
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp32({24'h000000, got}, {24'h000000, exp});
  endtask : cmp8

  task automatic set_en(input logic [4:0] v);
    @(posedge clk);
    en_wr  <= 1'b1;
    en_val <= v;
    @(posedge clk);
    en_wr  <= 1'b0;
    @(posedge clk);
    #1;
    cmp8({3'h0, en_reg}, {3'h0, v});
  endtask : set_en

  // Direct array access; answer is due exactly one cycle after take
  task automatic arr(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    a_req   <= 1'b1;
    a_wr    <= wr;
    a_addr  <= a;
    a_wdata <= d;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (a_ack !== 1'b1 && k < 20);
    q = a_rdata;
    cmp32(32'(k), 32'h1);
    @(posedge clk);
    a_req <= 1'b0;
  endtask : arr

  // Shape: {first cycle of bus request, cs extend, ras extend, delay, 0}
  task automatic fetch(input logic [31:0] a, input logic c);
    int k = 0;
    logic [3:0] first = 4'hF;
    logic cs = 1'b0, ras = 1'b0, dl = 1'b0;
    @(posedge clk);
    f_req  <= 1'b1;
    f_cach <= c;
    f_addr <= a;
    do begin
      @(posedge clk);
      #1;
      k++;
      if (x_req === 1'b1 && first == 4'hF) first = 4'(k);
      cs  |= (cs_ext === 1'b1);
      ras |= (ras_ext === 1'b1);
      dl  |= (b_dly === 1'b1);
    end while (f_ack !== 1'b1 && k < 40);
    q = f_rdata;
    n = 32'(k);
    s = {first, cs, ras, dl, 1'b0};
    @(posedge clk);
    f_req <= 1'b0;
  endtask : fetch

  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {clk, nrst, en_wr, f_req, f_cach, a_req, a_wr, ras_down, slow} = '0;
    {en_val, f_addr, a_addr, a_wdata} = '0;
    fail_count = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    cmp8({3'h0, en_reg}, 8'h00);
    for (int i = 0; i < 256; i++) arr(1'b1, dmic_pkg::TAG_WIN_BASE + 32'(i * 4), 32'h0);
    arr(1'b1, 32'hFFFFF014, 32'hFFFFFFFF);
    arr(1'b0, 32'hFFFFF014, 32'h0);
    cmp32(q, 32'h01FFFC01);
    arr(1'b1, 32'hFFFFF014, 32'h0);
    arr(1'b1, 32'hFFFFF7FC, 32'hA5C30F96);
    arr(1'b0, 32'hFFFFF7FC, 32'h0);
    cmp32(q, 32'hA5C30F96);
    arr(1'b1, 32'hFFFFF800, 32'h11111111);
    arr(1'b0, 32'hFFFFF800, 32'h0);
    cmp32(q, 32'h0);
    // Each enable bit alone locks the arrays
    for (int i = 0; i < 5; i++) begin
      set_en(5'(1 << i));
      arr(1'b1, 32'hFFFFF7FC, 32'hFFFFFFFF);
      arr(1'b0, 32'hFFFFF7FC, 32'h0);
      cmp32(q, 32'h0);
    end
    set_en(5'h00);
    arr(1'b0, 32'hFFFFF7FC, 32'h0);
    cmp32(q, 32'hA5C30F96);
    // Chip-select space 0 cached
    set_en(5'h01);
    fetch(32'h00000100, 1'b1);
    cmp8(s, 8'h28);
    cmp32(q, 32'h5A5A0100);
    cmp8({7'h00, x_dram}, 8'h00);
    fetch(32'h00000204, 1'b1);
    cmp8(s, 8'h18);
    fetch(32'h00000100, 1'b1);
    cmp8(s, 8'h18);
    fetch(32'h00000100, 1'b1);
    cmp8(s, 8'hF0);
    cmp32(n, 32'h1);
    cmp32(q, 32'h5A5A0100);
    fetch(32'h00000204, 1'b0);
    cmp8(s, 8'h10);
    cmp32(q, 32'h5A5A0204);
    fetch(32'h00400008, 1'b1);
    cmp8(s, 8'h10);
    // DRAM space, slow partner, RAS-down then normal
    ras_down <= 1'b1;
    slow     <= 1'b1;
    set_en(5'h10);
    fetch(32'h01000010, 1'b1);
    cmp8(s, 8'h26);
    cmp32(q, 32'h5B5A0010);
    cmp8({7'h00, x_dram}, 8'h01);
    ras_down <= 1'b0;
    slow     <= 1'b0;
    fetch(32'h01000414, 1'b1);
    cmp8(s, 8'h14);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule : dmic_tb_top
`default_nettype wire
